// file: core/jlc_core.sv
`timescale 1ns/1ps
`include "jlc_params.svh"

// Overview of operation
// - Jump-and-link writes PC+1 into bits 8:0, bits 31:9 keep their value.
// - The return address is stored first, the program counter loaded after.
// - Target is the source register, or the 9-bit source field when immediate.
// - Opcode 010111, effects 001i, condition 1111; done in 4 clocks.
// - With carry write, carry is set unless PC+1 wraps to zero.
// - Without result write the link is suppressed; a plain jump remains.
// - Jump-and-link neither saves nor restores the zero and carry flags.
// - Call, return, jump and jump-and-link share one opcode.
// - Hub opcode 000011 with source value 7 is the lock clear.
// - Lock clear forces the addressed lock bit to zero; a set from another party in the same cycle wins.
// - With carry write, carry takes the lock bit's prior state.
// - The hub keeps eight lock bits with identifiers 0 to 7.
// - Only the low three identifier bits select the lock.
// - With zero write, zero flag is set when the lock identifier is 0.
// - The masked identifier is written back only with result write.
// - Lock clear takes 8 to 23 clocks, served in the access window; the code takes 8 to 20.
module jlc_core #(
  parameter int HUB_PERIOD = `JLC_HUB_PERIOD,
  parameter int HUB_SLOT = `JLC_HUB_SLOT
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_issue,
  input wire jlc_pkg::jlc_word_t i_instr,
  input wire jlc_pkg::jlc_addr_t i_pc,
  input wire jlc_pkg::jlc_addr_t i_reg_addr,
  input wire jlc_pkg::jlc_word_t i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output jlc_pkg::jlc_word_t o_reg_rdata,
  input wire logic i_lock_set_valid,
  input wire jlc_pkg::jlc_lock_id_t i_lock_set_id,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output jlc_pkg::jlc_addr_t o_pc,
  output logic o_flag_z,
  output logic o_flag_c,
  output logic [7:0] o_lock_state
);
  import jlc_pkg::*;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // One opcode covers call, return, jump and jump-and-link; the effect
  // and field values alone tell them apart, so no further split is made.
  function automatic jlc_op_t decode_op(input jlc_word_t w);
    jlc_op_t op;
    op = OP_OTHER;
    if (w[`JLC_OP_HI:`JLC_OP_LO] == `JLC_OPC_JUMP) begin
      op = OP_JUMP_LINK;
    end else if (w[`JLC_OP_HI:`JLC_OP_LO] == `JLC_OPC_HUB &&
                 w[`JLC_SRC_HI:`JLC_SRC_LO] == `JLC_HUB_CLEAR) begin
      op = OP_LOCK_CLEAR;
    end
    return op;
  endfunction

  // The condition nibble holds one enable bit per carry and zero pair.
  function automatic logic cond_pass(input logic [3:0] cond, input logic c,
                                     input logic z);
    return cond[{c, z}];
  endfunction

  jlc_state_t state, next_state;
  jlc_word_t instr, next_instr;
  jlc_word_t dst_q, next_dst_q;
  jlc_addr_t pc_q, next_pc_q;
  jlc_addr_t target_q, next_target_q;
  logic exec_q, next_exec_q;
  logic got, next_got;
  logic prev, next_prev;
  logic [4:0] cnt, next_cnt;
  logic next_busy, next_done, next_illegal, next_flag_z, next_flag_c;
  jlc_addr_t next_pc;
  logic core_we;
  jlc_word_t core_wdata;
  logic hub_req, hub_grant, hub_prev;
  logic [2:0] rd_en;
  logic [26:0] rd_addr;
  logic [95:0] rd_data;
  jlc_op_t op_q;
  logic fx_z, fx_c, fx_r, fx_i;
  jlc_addr_t dst_field, src_field, link_val;
  jlc_lock_id_t lock_id;
  jlc_word_t link_word;

  assign op_q = decode_op(instr);
  assign fx_z = instr[`JLC_FX_Z];
  assign fx_c = instr[`JLC_FX_C];
  assign fx_r = instr[`JLC_FX_R];
  assign fx_i = instr[`JLC_FX_I];
  assign dst_field = instr[`JLC_DST_HI:`JLC_DST_LO];
  assign src_field = instr[`JLC_SRC_HI:`JLC_SRC_LO];
  assign link_val = pc_q + 9'h001;
  assign link_word = {dst_q[31:9], link_val};
  assign lock_id = dst_q[2:0];

  // ----------------------------------------------------------------
  // Register memory and hub lock pool
  // ----------------------------------------------------------------
  // Port 0 serves the software bus, ports 1 and 2 the destination and
  // source operands. A bus write in the cycle of a core write is lost.
  assign rd_en = {{2{state == S_IDLE && i_issue}}, i_reg_rd};
  assign rd_addr = {i_instr[`JLC_SRC_HI:`JLC_SRC_LO],
                    i_instr[`JLC_DST_HI:`JLC_DST_LO], i_reg_addr};
  assign o_reg_rdata = rd_data[31:0];

  jlc_regfile #(.DEPTH(512), .WIDTH(32), .AW(9), .NRD(3)) u_regs (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_rd_en(rd_en),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data),
    .i_wr_en(core_we || i_reg_wr),
    .i_wr_addr(core_we ? dst_field : i_reg_addr),
    .i_wr_data(core_we ? core_wdata : i_reg_wdata)
  );

  jlc_lock_pool #(.N(8), .PERIOD(HUB_PERIOD), .SLOT(HUB_SLOT)) u_locks (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr_req(hub_req),
    .i_clr_id(lock_id),
    .i_set_valid(i_lock_set_valid),
    .i_set_id(i_lock_set_id),
    .o_grant(hub_grant),
    .o_prev(hub_prev),
    .o_locks(o_lock_state)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_dst_q = dst_q;
    next_pc_q = pc_q;
    next_target_q = target_q;
    next_exec_q = exec_q;
    next_got = got;
    next_prev = prev;
    next_cnt = (state == S_IDLE) ? 5'h01 : 5'(cnt + 5'h01);
    next_busy = o_busy;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_pc = o_pc;
    next_flag_z = o_flag_z;
    next_flag_c = o_flag_c;
    core_we = 1'b0;
    core_wdata = link_word;
    hub_req = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (i_issue) begin
          next_instr = i_instr;
          next_pc_q = i_pc;
          next_got = 1'b0;
          next_exec_q = cond_pass(i_instr[`JLC_CON_HI:`JLC_CON_LO], o_flag_c, o_flag_z);
          if (decode_op(i_instr) == OP_OTHER) begin
            next_done = 1'b1;
            next_illegal = 1'b1;
            next_pc = i_pc + 9'h001;
          end else begin
            next_state = S_FETCH;
            next_busy = 1'b1;
          end
        end
      end
      S_FETCH: begin
        next_dst_q = rd_data[63:32];
        next_target_q = fx_i ? src_field : rd_data[72:64];
        next_state = (op_q == OP_JUMP_LINK) ? S_LINK : S_HUB_WAIT;
      end
      S_LINK: begin
        core_we = exec_q && fx_r;
        next_state = S_JUMP;
      end
      S_JUMP: begin
        next_state = S_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_pc = exec_q ? target_q : link_val;
        if (exec_q && fx_c) begin
          next_flag_c = (link_val != 9'h000);
        end
        if (exec_q && fx_z) begin
          next_flag_z = (link_word == 32'h0000_0000);
        end
      end
      S_HUB_WAIT: begin
        // Stalls until the rotating window serves the request.
        hub_req = exec_q && !got;
        if (hub_grant) begin
          next_got = 1'b1;
          next_prev = hub_prev;
        end
        if ((got || hub_grant || !exec_q) && cnt >= 5'(`JLC_HUB_MIN_CLOCKS - 2)) begin
          next_state = S_HUB_DONE;
        end
      end
      S_HUB_DONE: begin
        next_state = S_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_pc = link_val;
        core_we = exec_q && fx_r;
        core_wdata = {29'h0000_0000, lock_id};
        if (exec_q && fx_c) begin
          next_flag_c = prev;
        end
        if (exec_q && fx_z) begin
          next_flag_z = (lock_id == 3'h0);
        end
      end
      default: begin
        next_state = S_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // Flags are plain state: nothing here saves or restores them.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      instr <= 32'h0000_0000;
      dst_q <= 32'h0000_0000;
      pc_q <= 9'h000;
      target_q <= 9'h000;
      exec_q <= 1'b0;
      got <= 1'b0;
      prev <= 1'b0;
      cnt <= 5'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_pc <= 9'h000;
      o_flag_z <= 1'b0;
      o_flag_c <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      dst_q <= next_dst_q;
      pc_q <= next_pc_q;
      target_q <= next_target_q;
      exec_q <= next_exec_q;
      got <= next_got;
      prev <= next_prev;
      cnt <= next_cnt;
      o_busy <= next_busy;
      o_done <= next_done;
      o_illegal <= next_illegal;
      o_pc <= next_pc;
      o_flag_z <= next_flag_z;
      o_flag_c <= next_flag_c;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_link_low_bits: assert property (
    (state == S_FETCH && op_q == OP_JUMP_LINK && exec_q && fx_r) |=>
      (core_we && core_wdata[31:9] == $past(rd_data[63:41]) &&
       core_wdata[8:0] == pc_q + 9'h001))
    else $error("Link word does not keep high bits or hold PC+1.");

  chk_link_then_jump: assert property (
    (state == S_LINK && core_we) |=> !o_done ##1 (o_done && o_pc == target_q))
    else $error("Program counter not loaded after the link write.");

  chk_jump_target: assert property (
    (state == S_FETCH && op_q == OP_JUMP_LINK) |=>
      target_q == (fx_i ? src_field : $past(rd_data[72:64])))
    else $error("Jump target taken from the wrong operand.");

  chk_jump_four: assert property (
    (state == S_IDLE && i_issue && decode_op(i_instr) == OP_JUMP_LINK) |=>
      o_busy [*3] ##1 (o_done && !o_busy))
    else $error("Jump-and-link did not finish in four clocks.");

  chk_jump_carry: assert property (
    (state == S_JUMP && exec_q && fx_c) |=> o_flag_c == ($past(pc_q) != `JLC_PC_TOP))
    else $error("Carry after jump-and-link is wrong.");

  chk_no_result: assert property (
    (state == S_FETCH && op_q == OP_JUMP_LINK && !fx_r) |=> !core_we ##1 !core_we)
    else $error("Link written without result effect.");

  chk_flags_kept: assert property (
    (o_done && !fx_z && !fx_c) |-> ($stable(o_flag_z) && $stable(o_flag_c)))
    else $error("Flag changed without its effect bit.");

  chk_lock_carry: assert property (
    (state == S_HUB_DONE && exec_q && fx_c) |=> o_flag_c == $past(prev))
    else $error("Carry does not show the prior lock state.");

  chk_lock_zero: assert property (
    (state == S_HUB_DONE && exec_q && fx_z) |=> o_flag_z == ($past(dst_q[2:0]) == 3'h0))
    else $error("Zero flag does not reflect the lock identifier.");

  chk_lock_result: assert property (
    (state == S_HUB_DONE) |-> (core_we == (exec_q && fx_r)) &&
      (!core_we || core_wdata == {29'h0000_0000, dst_q[2:0]}))
    else $error("Lock identifier write-back is wrong.");

  chk_hub_span: assert property (
    (state == S_IDLE && i_issue && decode_op(i_instr) == OP_LOCK_CLEAR) |=>
      (!o_done) [*7] ##[1:16] o_done)
    else $error("Lock clear outside 8 to 23 clocks.");

  cov_jump_link: cover property (state == S_LINK && core_we ##2 o_done);
  cov_lock_was_set: cover property (state == S_HUB_DONE && exec_q && prev);
  cov_hub_long_wait: cover property (o_done && cnt >= 5'h0F);
  cov_self_link: cover property (state == S_LINK && core_we && dst_field == target_q);

endmodule

// file: core/jlc_lock_pool.sv
`timescale 1ns/1ps
`include "jlc_params.svh"

module jlc_lock_pool #(
  parameter int N = `JLC_LOCK_COUNT,
  parameter int PERIOD = `JLC_HUB_PERIOD,
  parameter int SLOT = `JLC_HUB_SLOT
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clr_req,
  input wire logic [$clog2(N)-1:0] i_clr_id,
  input wire logic i_set_valid,
  input wire logic [$clog2(N)-1:0] i_set_id,
  output logic o_grant,
  output logic o_prev,
  output logic [N-1:0] o_locks
);
  import jlc_pkg::*;

  localparam int PW = $clog2(PERIOD);

  logic [PW-1:0] win, next_win;
  logic [N-1:0] next_locks;
  logic fire;

  // ----------------------------------------------------------------
  // Rotating access window
  // ----------------------------------------------------------------
  // The clear is served only in the slot of this core.
  assign fire = i_clr_req && (win == PW'(SLOT));
  assign next_win = (win == PW'(PERIOD - 1)) ? '0 : PW'(win + 1'b1);

  // ----------------------------------------------------------------
  // Lock bits
  // ----------------------------------------------------------------
  // A set from another party in the same cycle wins over the clear.
  for (genvar g = 0; g < N; g++) begin : g_lock
    always_comb begin
      next_locks[g] = o_locks[g] && !(fire && i_clr_id == g);
      if (i_set_valid && i_set_id == g) begin
        next_locks[g] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      win <= '0;
      o_locks <= `JLC_LOCKS_RESET;
      o_grant <= 1'b0;
      o_prev <= 1'b0;
    end else begin
      win <= next_win;
      o_locks <= next_locks;
      o_grant <= fire;
      o_prev <= fire ? o_locks[i_clr_id] : o_prev;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_lock_clear_bit: assert property (
    (fire && !(i_set_valid && i_set_id == i_clr_id)) |=>
      (o_grant && !o_locks[$past(i_clr_id)]))
    else $error("Cleared lock bit is not zero.");

  chk_window_only: assert property (
    o_grant |-> $past(win) == PW'(SLOT))
    else $error("Lock clear served outside the access window.");

endmodule

// file: core/jlc_params.svh
`ifndef JLC_PARAMS_SVH
`define JLC_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction word field positions
// ----------------------------------------------------------------
`define JLC_OP_HI 31
`define JLC_OP_LO 26
`define JLC_FX_Z 25
`define JLC_FX_C 24
`define JLC_FX_R 23
`define JLC_FX_I 22
`define JLC_CON_HI 21
`define JLC_CON_LO 18
`define JLC_DST_HI 17
`define JLC_DST_LO 9
`define JLC_SRC_HI 8
`define JLC_SRC_LO 0

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define JLC_OPC_JUMP 6'h17
`define JLC_OPC_HUB 6'h03
`define JLC_HUB_CLEAR 9'h007
`define JLC_COND_ALWAYS 4'hF
`define JLC_PC_TOP 9'h1FF

// ----------------------------------------------------------------
// Timing counts in clock cycles and reset values
// ----------------------------------------------------------------
`define JLC_JUMP_CLOCKS 4
`define JLC_HUB_MIN_CLOCKS 8
`define JLC_HUB_MAX_CLOCKS 23
`define JLC_HUB_PERIOD 16
`define JLC_HUB_SLOT 0
`define JLC_LOCK_COUNT 8
`define JLC_LOCKS_RESET 8'h00

`endif

// file: core/jlc_pkg.sv
package jlc_pkg;

  typedef logic [31:0] jlc_word_t;
  typedef logic [8:0] jlc_addr_t;
  typedef logic [2:0] jlc_lock_id_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_LINK = 3'h3,
    S_JUMP = 3'h2,
    S_HUB_WAIT = 3'h5,
    S_HUB_DONE = 3'h4
  } jlc_state_t;

  typedef enum logic [1:0] {
    OP_JUMP_LINK = 2'h0,
    OP_LOCK_CLEAR = 2'h1,
    OP_OTHER = 2'h2
  } jlc_op_t;

endpackage

// file: core/jlc_regfile.sv
`timescale 1ns/1ps

module jlc_regfile #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 32,
  parameter int AW = 9,
  parameter int NRD = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [NRD-1:0] i_rd_en,
  input wire logic [NRD*AW-1:0] i_rd_addr,
  output logic [NRD*WIDTH-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [NRD*WIDTH-1:0] next_rd_data;

  // Read data show zero outside the cycle after a read.
  always_comb begin
    next_rd_data = '0;
    for (int k = 0; k < NRD; k++) begin
      if (i_rd_en[k]) begin
        next_rd_data[k*WIDTH +: WIDTH] = mem[i_rd_addr[k*AW +: AW]];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

endmodule

// file: sim/jlc_hub_peer.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Another hub party that sets lock bits with one-cycle pulses.
// ------------------------------------------------------------
module jlc_hub_peer (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [2:0] i_id,
  output logic o_set_valid,
  output logic [2:0] o_set_id
);
  logic [2:0] last_id;

  initial begin
    o_set_valid = 1'b0;
    o_set_id = 3'h0;
    last_id = 3'h0;
  end

  // Outside a pulse the id lines carry the inverse of the last id, so a core
  // that samples them without the valid pulse sees a wrong lock, not a stale one.
  always @(posedge i_clk) begin
    if (i_req) begin
      o_set_valid <= 1'b1;
      o_set_id <= i_id;
      last_id <= i_id;
    end else begin
      o_set_valid <= 1'b0;
      o_set_id <= ~last_id;
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps

module tb;
  import jlc_pkg::*;
  logic i_clk, i_resetn, i_issue, i_reg_wr, i_reg_rd, set_req, set_v;
  logic o_busy, o_done, o_illegal, o_flag_z, o_flag_c;
  jlc_word_t i_instr, i_reg_wdata, o_reg_rdata, d;
  jlc_addr_t i_pc, i_reg_addr, o_pc;
  logic [2:0] req_id;
  jlc_lock_id_t set_id;
  logic [7:0] o_lock_state;
  int num_errors = 0;
  int n_checks = 0;
  int n;

  jlc_core DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_issue(i_issue),
    .i_instr(i_instr), .i_pc(i_pc), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_lock_set_valid(set_v),
    .i_lock_set_id(set_id), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .o_pc(o_pc), .o_flag_z(o_flag_z),
    .o_flag_c(o_flag_c), .o_lock_state(o_lock_state));

  jlc_hub_peer PEER (.i_clk(i_clk), .i_req(set_req), .i_id(req_id),
    .o_set_valid(set_v), .o_set_id(set_id));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input jlc_addr_t a, input jlc_word_t v);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input jlc_addr_t a, output jlc_word_t v);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    v = o_reg_rdata;
  endtask

  // Returns the number of cycles from the issue cycle to the done cycle.
  task automatic run(input jlc_word_t w, input jlc_addr_t pc, output int c);
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_instr <= w;
    i_pc <= pc;
    @(posedge i_clk);
    i_issue <= 1'b0;
    c = 1;
    #1;
    while (o_done !== 1'b1 && c < 40) begin
      @(posedge i_clk);
      #1;
      c++;
    end
  endtask

  task automatic set_lock(input logic [2:0] id);
    @(posedge i_clk);
    set_req <= 1'b1;
    req_id <= id;
    @(posedge i_clk);
    set_req <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  function automatic jlc_word_t ins(input logic [5:0] op, input logic [3:0] zcri,
      input jlc_addr_t dst, input jlc_addr_t src);
    return {op, zcri, 4'hF, dst, src};
  endfunction

  function automatic jlc_word_t cins(input logic [5:0] op, input logic [3:0] zcri,
      input logic [3:0] cond, input jlc_addr_t dst, input jlc_addr_t src);
    return {op, zcri, cond, dst, src};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_link_reg();
    wr(9'h010, 32'hDEAD_BEEF);
    wr(9'h011, 32'h0000_0123);
    run(ins(6'h17, 4'h6, 9'h010, 9'h011), 9'h040, n);
    chk("link_cycles", 4, n);
    chk("link_pc", 32'h123, o_pc);
    chk("link_c", 1, o_flag_c);
    rd(9'h010, d);
    chk("link_word", 32'hDEAD_BE41, d);
  endtask

  // From the top address the return address wraps, so carry must clear.
  task automatic t_link_top();
    wr(9'h012, 32'h0000_0000);
    run(ins(6'h17, 4'hF, 9'h012, 9'h055), 9'h1FF, n);
    chk("top_pc", 32'h055, o_pc);
    chk("top_c", 0, o_flag_c);
    chk("top_z", 1, o_flag_z);
    rd(9'h012, d);
    chk("top_word", 32'h0, d);
  endtask

  task automatic t_no_result();
    wr(9'h013, 32'h1234_5678);
    run(ins(6'h17, 4'h1, 9'h013, 9'h077), 9'h041, n);
    chk("nr_cycles", 4, n);
    chk("nr_illegal", 0, o_illegal);
    chk("nr_pc", 32'h077, o_pc);
    chk("nr_flags", 2'b10, {o_flag_z, o_flag_c});
    rd(9'h013, d);
    chk("nr_word", 32'h1234_5678, d);
  endtask

  task automatic t_self_link();
    wr(9'h014, 32'hFFFF_F0AA);
    run(ins(6'h17, 4'h2, 9'h014, 9'h014), 9'h020, n);
    chk("self_pc", 32'h0AA, o_pc);
    chk("self_flags", 2'b10, {o_flag_z, o_flag_c});
    rd(9'h014, d);
    chk("self_word", 32'hFFFF_F021, d);
  endtask

  // Conditions see the flags at issue; on entry Z is set and C is clear.
  task automatic t_cond();
    wr(9'h016, 32'h0000_0ABC);
    run(cins(6'h17, 4'hF, 4'hC, 9'h016, 9'h033), 9'h060, n);
    chk("skip_cycles", 4, n);
    chk("skip_pc", 32'h061, o_pc);
    chk("skip_flags", 2'b10, {o_flag_z, o_flag_c});
    rd(9'h016, d);
    chk("skip_word", 32'h0000_0ABC, d);
    run(cins(6'h17, 4'hF, 4'hA, 9'h016, 9'h033), 9'h060, n);
    chk("cond_pc", 32'h033, o_pc);
    chk("cond_flags", 2'b01, {o_flag_z, o_flag_c});
    rd(9'h016, d);
    chk("cond_word", 32'h0000_0A61, d);
    set_lock(3'h2);
    wr(9'h017, 32'h0000_000A);
    run(cins(6'h03, 4'hE, 4'h3, 9'h017, 9'h007), 9'h062, n);
    chk("skip_hub_range", 1, n >= 8 && n <= 23);
    chk("skip_hub_bit", 1, o_lock_state[2]);
    chk("skip_hub_flags", 2'b01, {o_flag_z, o_flag_c});
    rd(9'h017, d);
    chk("skip_hub_dest", 32'h0000_000A, d);
  endtask

  task automatic t_lock_all();
    for (int i = 0; i < 8; i++) begin
      set_lock(3'(i));
    end
    chk("locks_set", 8'hFF, o_lock_state);
    for (int i = 0; i < 8; i++) begin
      wr(9'h020, (i == 0) ? 32'h8 : 32'(i));
      run(ins(6'h03, 4'hE, 9'h020, 9'h007), 9'h030, n);
      chk("hub_in_range", 1, n >= 8 && n <= 23);
      chk("clr_c", 1, o_flag_c);
      chk("clr_z", i == 0, o_flag_z);
      chk("clr_bit", 0, o_lock_state[i]);
      rd(9'h020, d);
      chk("clr_id", i, d);
    end
    run(ins(6'h03, 4'hE, 9'h020, 9'h007), 9'h030, n);
    chk("reclr_c", 0, o_flag_c);
    chk("locks_clr", 8'h00, o_lock_state);
  endtask

  task automatic t_lock_quiet();
    set_lock(3'h0);
    wr(9'h021, 32'h8);
    run(ins(6'h03, 4'h0, 9'h021, 9'h007), 9'h031, n);
    chk("quiet_flags", 2'b00, {o_flag_z, o_flag_c});
    chk("quiet_bit", 0, o_lock_state[0]);
    rd(9'h021, d);
    chk("quiet_dest", 32'h8, d);
  endtask

  task automatic t_illegal();
    jlc_word_t w [2];
    w[0] = ins(6'h00, 4'h2, 9'h015, 9'h007);
    w[1] = ins(6'h03, 4'hE, 9'h020, 9'h006);
    for (int i = 0; i < 2; i++) begin
      run(w[i], 9'h050, n);
      chk("ill_cycles", 1, n);
      chk("ill_flag", 1, o_illegal);
      chk("ill_pc", 32'h051, o_pc);
    end
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    i_resetn = 1'b0;
    i_issue = 1'b0;
    i_instr = '0;
    i_pc = '0;
    i_reg_addr = '0;
    i_reg_wdata = '0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    set_req = 1'b0;
    req_id = 3'h0;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk("rst_state", 11'h000, {o_busy, o_flag_z, o_flag_c, o_lock_state});
    t_link_reg();
    t_link_top();
    t_no_result();
    t_self_link();
    t_cond();
    t_lock_all();
    t_lock_quiet();
    t_illegal();
    conclude();
  end

  // The whole run needs well under 2000 cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    conclude();
  end
endmodule
